// file: design/ubp_pkg.sv
package ubp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ      = 50_000_000;  // System clock rate
  localparam int BASE_PERIOD_US   = 5000;        // Evaluation time base, 5 ms
  localparam int BASE_TICK_CYCLES = BASE_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Scaling and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  RESET_PCT       = 7'h61;         // Drop-out at 97 percent
  localparam logic [6:0]  FULL_PCT        = 7'h64;         // 100 percent
  localparam logic [31:0] RATIO_SCALE     = 32'h0000_2710; // 100 percent in 0.01 % steps
  localparam logic [41:0] DIV_OUT_SCALE   = 42'h000_0000_03E8; // Ratio output, 1/1000
  localparam logic [31:0] INV_UNITY_SQ    = 32'h000F_4240; // 1000 squared
  localparam logic [15:0] NEG_LEVEL_RST   = 16'h0014;      // 0.20 x In in 0.01 steps
  localparam logic [15:0] RATIO_LEVEL_RST = 16'h07D0;      // 20.00 percent
  localparam logic        SEL_NEG_PU      = 1'h0;          // Per-unit negative sequence
  localparam logic        SEL_RATIO       = 1'h1;          // Negative/positive ratio

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2, MODE_TEST_BLK = 3'h3, MODE_OFF = 3'h4
  } ubp_mode_t;

  typedef enum logic [1:0] {
    COND_NORMAL = 2'h0, COND_START = 2'h1, COND_TRIP = 2'h2, COND_BLOCKED = 2'h3
  } ubp_cond_t;

  typedef enum logic [1:0] {
    DLY_INSTANT = 2'h0, DLY_FIXED = 2'h1, DLY_INVERSE = 2'h2
  } ubp_delay_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_START = 4'h2, ST_TRIP = 4'h4, ST_BLOCK = 4'h8
  } ubp_state_t;

  // Percentage scaling, used for both sides of the drop-out compare
  function automatic logic [39:0] f_pct(input logic [31:0] x, input logic [6:0] pct);
    f_pct = 40'(x) * 40'(pct);
  endfunction

endpackage

// file: design/ubp_timer_if.sv
`timescale 1ns/100ps
// Trip timer hookup between stage control and its delay timer
interface ubp_timer_if;
  import ubp_pkg::*;
  logic        eval;        // Evaluation pulse, once per 5 ms
  logic        run;         // Stage started, timing active
  ubp_delay_t  delay_mode;  // Fixed or inverse characteristic
  logic [19:0] fixed_ticks; // Fixed delay in 5 ms ticks
  logic [39:0] inv_k;       // Inverse curve multiplier
  logic [15:0] ratio_pm;    // Measured over set, 1/1000
  logic        expired;     // Operate time reached

  modport ctrl  (output eval, run, delay_mode, fixed_ticks, inv_k, ratio_pm, input expired);
  modport timer (input eval, run, delay_mode, fixed_ticks, inv_k, ratio_pm, output expired);
endinterface

// file: design/ubp_trip_timer.sv
`timescale 1ns/100ps
module ubp_trip_timer
  import ubp_pkg::*;
(
  input logic         clk,
  input logic         resetn,
  ubp_timer_if.timer  tif
);

  // ----------------------------------------------------------------
  // Accumulators
  // ----------------------------------------------------------------
  logic [19:0] fixed_cnt;  // Elapsed ticks since start
  logic [39:0] inv_acc;    // Integral of curve excess
  logic [31:0] ratio_sq;   // Measured ratio squared
  logic [39:0] excess;     // Excess over the set level squared
  logic [40:0] inv_sum;    // Next integral, one guard bit
  logic [20:0] fixed_next; // Next tick count, one guard bit

  // Curve excess, zero below set level
  always_comb begin
    ratio_sq   = 32'(tif.ratio_pm) * 32'(tif.ratio_pm);
    excess     = (ratio_sq > INV_UNITY_SQ) ? 40'(ratio_sq - INV_UNITY_SQ) : 40'h0;
    inv_sum    = 41'(inv_acc) + 41'(excess);
    fixed_next = 21'(fixed_cnt) + 21'h1;
  end

  // Fixed delay counter, cleared on release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fixed_cnt <= 20'h0;
    end else if (!tif.run) begin
      fixed_cnt <= 20'h0;
    end else if (tif.eval && !fixed_next[20]) begin
      fixed_cnt <= fixed_next[19:0];
    end
  end

  // Inverse integral, saturating; curve time falls with squared current
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inv_acc <= 40'h0;
    end else if (!tif.run) begin
      inv_acc <= 40'h0;
    end else if (tif.eval) begin
      inv_acc <= inv_sum[40] ? 40'hFF_FFFF_FFFF : inv_sum[39:0];
    end
  end

  // Expiry flag, sticky while running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tif.expired <= 1'b0;
    end else if (!tif.run) begin
      tif.expired <= 1'b0;
    end else if (tif.eval && !tif.expired) begin
      case (tif.delay_mode)
        DLY_FIXED:   tif.expired <= fixed_next >= 21'(tif.fixed_ticks);
        DLY_INVERSE: tif.expired <= inv_sum >= 41'(tif.inv_k);
        default:     tif.expired <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_timer_release;
    @(posedge clk) disable iff (!resetn) !tif.run |=> !tif.expired;
  endproperty
  a_timer_release: assert property (p_timer_release) else $error("timer kept expiry");

  property p_fixed_expiry;
    @(posedge clk) disable iff (!resetn)
      tif.run && tif.eval && !tif.expired && tif.delay_mode == DLY_FIXED
      && fixed_next >= 21'(tif.fixed_ticks) |=> tif.expired;
  endproperty
  a_fixed_expiry: assert property (p_fixed_expiry) else $error("fixed delay missed");

endmodule // ubp_trip_timer

// file: design/ubp_unbalance_stage.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Current unbalance pick-up stage
// ------------------------------------------------------------------
// Operation
// - Two modes: negative sequence or ratio
// - Ratio mode requires minimum phase loading current
// - Sequence magnitudes come from phase currents
// - All measurements refreshed every 5 ms
// - Zero sequence, angles only for recording
// - Node mode On/Blocked/Test/Test-Blocked/Off
// - Force condition when forcing globally enabled; only Start, Trip and Blocked are forced
// - Magnitude select, per-unit after reset; the select is a plain port with no reset value
// - Static settings ignore setting group
// - Pick up when quantity exceeds level
// - Drop out below 97 percent of level
// - Continuous measured over set ratio
// - Group switch applies without restart
// - Negative level 0.01 steps, default 0.20
// - Ratio level 0.01 percent, default 20
// - Behaviour shows effective node mode
// - Condition shows Normal/Start/Trip/Blocked
// - Block at pick-up gives Blocked only
// - Blocking clears start, releases timing
// - Block must precede trip by 5 ms
// - Instant, fixed or inverse trip timing
module ubp_unbalance_stage
  import ubp_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_TICK_CYCLES  // Cycles per evaluation tick
) (
  input  logic              clk,
  input  logic              resetn,
  input  logic              block_in,
  input  logic [15:0]       pos_seq_mag,
  input  logic [15:0]       neg_seq_mag,
  input  logic [15:0]       zero_seq_mag,
  input  logic [15:0]       pos_seq_ang,
  input  logic [15:0]       neg_seq_ang,
  input  logic [15:0]       zero_seq_ang,
  input  logic [2:0][15:0]  phase_mag,
  input  logic [15:0]       min_load_level,
  input  logic [2:0]        group_sel,
  input  logic [7:0][15:0]  neg_seq_pickup_level,
  input  logic [7:0][15:0]  seq_ratio_pickup_level,
  input  logic              mode_permit,
  input  ubp_mode_t         node_operating_mode,
  input  logic              force_permit,
  input  ubp_cond_t         force_status,
  input  logic              magnitude_select,
  input  ubp_delay_t        delay_mode,
  input  logic [19:0]       fixed_time_delay,
  input  logic [39:0]       inverse_time_delay,
  output logic              start_out,
  output logic              trip_out,
  output logic              blocked_out,
  output ubp_cond_t         condition,
  output ubp_mode_t         behaviour,
  output logic [15:0]       meas_set_ratio,
  output logic              record_strobe,
  output logic [15:0]       record_zero_mag,
  output logic [15:0]       record_pos_ang,
  output logic [15:0]       record_neg_ang,
  output logic [15:0]       record_zero_ang
);

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1); // Divider terminal count

  logic [17:0] tick_cnt; // Divider count
  logic        tick;     // Sample capture pulse
  logic        eval;     // Decision pulse, one cycle after capture

  // 5 ms divider, single clock domain throughout
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 18'h0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= 18'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'h1;
      tick     <= 1'b0;
    end
  end

  // Decision runs on the freshly captured sample
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eval <= 1'b0;
    end else begin
      eval <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Sample capture
  // ----------------------------------------------------------------
  logic [15:0]      pos_s;     // Positive sequence magnitude
  logic [15:0]      neg_s;     // Negative sequence magnitude
  logic [15:0]      zero_s;    // Zero sequence, recording only
  logic [2:0][15:0] ang_s;     // Sequence angles, recording only
  logic [2:0][15:0] phase_s;   // Phase fundamentals
  logic             blk_s;     // Block input at sample time
  logic [15:0]      neg_lvl;   // Active group negative level
  logic [15:0]      ratio_lvl; // Active group ratio level

  // Measurements, all on the same time base; magnitudes are the front
  // end's symmetrical components of the three phase channels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_s   <= 16'h0;
      neg_s   <= 16'h0;
      zero_s  <= 16'h0;
      ang_s   <= '0;
      phase_s <= '0;
    end else if (tick) begin
      pos_s   <= pos_seq_mag;
      neg_s   <= neg_seq_mag;
      zero_s  <= zero_seq_mag;
      ang_s   <= {zero_seq_ang, neg_seq_ang, pos_seq_ang};
      phase_s <= phase_mag;
    end
  end

  // Block input sampled once per tick; later arrival misses this tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blk_s <= 1'b0;
    end else if (tick) begin
      blk_s <= block_in;
    end
  end

  // Group levels follow the group select live; stage state is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      neg_lvl   <= NEG_LEVEL_RST;
      ratio_lvl <= RATIO_LEVEL_RST;
    end else if (tick) begin
      neg_lvl   <= neg_seq_pickup_level[group_sel];
      ratio_lvl <= seq_ratio_pickup_level[group_sel];
    end
  end

  // ----------------------------------------------------------------
  // Decision logic
  // ----------------------------------------------------------------
  ubp_mode_t  eff_mode;     // Effective node mode
  ubp_state_t state;        // Stage state
  ubp_state_t next_state;   // Stage state after this cycle
  ubp_cond_t  next_cond;    // Condition after force
  logic       sel_ratio;    // Ratio mode chosen
  logic [31:0] q;           // Measured quantity, scaled
  logic [31:0] ref_v;       // Pick-up level, same scale
  logic       over;         // Above pick-up
  logic       drop;         // Below reset level
  logic       load_ok;      // Minimum load present
  logic       stage_on;     // Node not switched off
  logic       blk;          // Any blocking source
  logic       picked;       // Pick-up element held
  logic       next_picked;  // Pick-up element next
  logic       force_active; // Forced condition in effect
  ubp_timer_if tif ();      // Trip timer hookup

  // Quantities; ratio mode cross-multiplies to avoid a divider in the path
  always_comb begin
    eff_mode  = mode_permit ? node_operating_mode : MODE_ON;
    sel_ratio = magnitude_select == SEL_RATIO;
    q         = sel_ratio ? 32'(neg_s) * RATIO_SCALE : 32'(neg_s);
    ref_v     = sel_ratio ? 32'(pos_s) * 32'(ratio_lvl) : 32'(neg_lvl);
    over      = q > ref_v;
    drop      = f_pct(q, FULL_PCT) < f_pct(ref_v, RESET_PCT);
    load_ok   = !sel_ratio || phase_s[0] >= min_load_level
                || phase_s[1] >= min_load_level || phase_s[2] >= min_load_level;
    // Mode, force and select are plain ports, never indexed by group
    stage_on  = eff_mode != MODE_OFF;
    blk       = blk_s || eff_mode == MODE_BLOCKED || eff_mode == MODE_TEST_BLK;
    next_picked = stage_on && load_ok && (picked ? !drop : over);
  end

  // Next state, only on evaluation pulses
  always_comb begin
    next_state = state;
    if (eval) begin
      if (!next_picked) begin
        next_state = ST_IDLE;
      end else if (blk) begin
        next_state = ST_BLOCK;
      end else begin
        case (state)
          ST_TRIP:  next_state = ST_TRIP;
          ST_START: next_state = tif.expired ? ST_TRIP : ST_START;
          default:  next_state = (delay_mode == DLY_INSTANT) ? ST_TRIP : ST_START;
        endcase
      end
    end
  end

  // Condition code, with force override
  always_comb begin
    force_active = force_permit && force_status != COND_NORMAL;
    case (next_state)
      ST_START: next_cond = COND_START;
      ST_TRIP:  next_cond = COND_TRIP;
      ST_BLOCK: next_cond = COND_BLOCKED;
      default:  next_cond = COND_NORMAL;
    endcase
    if (force_active) begin
      next_cond = force_status;
    end
  end

  // State and pick-up memory
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state  <= ST_IDLE;
      picked <= 1'b0;
    end else if (eval) begin
      state  <= next_state;
      picked <= next_picked;
    end
  end

  // Outputs; Test mode shows conditions but never drives a trip; Test-Blocked does not mask it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      condition   <= COND_NORMAL;
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
      behaviour   <= MODE_ON;
    end else begin
      condition   <= next_cond;
      start_out   <= next_cond == COND_START || next_cond == COND_TRIP;
      trip_out    <= next_cond == COND_TRIP && eff_mode != MODE_TEST;
      blocked_out <= next_cond == COND_BLOCKED;
      behaviour   <= eff_mode;
    end
  end

  // Fault record on each ON transition; angles never reach the decision
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      record_strobe   <= 1'b0;
      record_zero_mag <= 16'h0;
      record_pos_ang  <= 16'h0;
      record_neg_ang  <= 16'h0;
      record_zero_ang <= 16'h0;
    end else if (next_state != state && next_state != ST_IDLE) begin
      record_strobe   <= 1'b1;
      record_zero_mag <= zero_s;
      record_pos_ang  <= ang_s[0];
      record_neg_ang  <= ang_s[1];
      record_zero_ang <= ang_s[2];
    end else begin
      record_strobe   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Trip timer
  // ----------------------------------------------------------------
  assign tif.eval        = eval;
  assign tif.run         = state == ST_START;
  assign tif.delay_mode  = delay_mode;
  assign tif.fixed_ticks = fixed_time_delay;
  assign tif.inv_k       = inverse_time_delay;
  assign tif.ratio_pm    = meas_set_ratio;

  ubp_trip_timer u_timer (
    .clk    (clk),
    .resetn (resetn),
    .tif    (tif.timer)
  );

  // ----------------------------------------------------------------
  // Measured over set ratio, serial divider
  // ----------------------------------------------------------------
  logic        div_busy; // Division running
  logic [5:0]  div_cnt;  // Bits remaining
  logic [41:0] div_num;  // Dividend, shifted out MSB first
  logic [31:0] div_den;  // Divisor
  logic [32:0] div_rem;  // Partial remainder
  logic [41:0] div_quo;  // Partial quotient
  logic [32:0] rem_sh;   // Remainder with next bit
  logic        take;     // Subtract this step
  logic [41:0] quo_next; // Quotient after this step

  // One quotient bit per clock; 42 clocks fit easily inside 5 ms
  always_comb begin
    rem_sh   = {div_rem[31:0], div_num[41]};
    take     = rem_sh >= {1'b0, div_den};
    quo_next = {div_quo[40:0], take};
  end

  // Divider datapath, restarted on every evaluation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_busy <= 1'b0;
      div_cnt  <= 6'h0;
      div_num  <= 42'h0;
      div_den  <= 32'h0;
      div_rem  <= 33'h0;
      div_quo  <= 42'h0;
    end else if (eval) begin
      div_busy <= 1'b1;
      div_cnt  <= 6'h2A;
      div_num  <= 42'(q) * DIV_OUT_SCALE;
      div_den  <= ref_v;
      div_rem  <= 33'h0;
      div_quo  <= 42'h0;
    end else if (div_busy) begin
      div_num  <= {div_num[40:0], 1'b0};
      div_rem  <= take ? rem_sh - {1'b0, div_den} : rem_sh;
      div_quo  <= quo_next;
      div_cnt  <= div_cnt - 6'h1;
      div_busy <= div_cnt != 6'h1;
    end
  end

  // Saturating result; zero level reads as full scale
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meas_set_ratio <= 16'h0;
    end else if (div_busy && div_cnt == 6'h1) begin
      meas_set_ratio <= (div_den == 32'h0 || |quo_next[41:16]) ? 16'hFFFF
                        : quo_next[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [17:0] gap_cnt; // Cycles since last tick

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_cnt <= 18'h3FFFF; // One below zero, so the first tick sees a full period
    end else begin
      gap_cnt <= tick ? 18'h0 : gap_cnt + 18'h1;
    end
  end

  sequence s_capture;
    tick ##1 eval ##1 !eval;
  endsequence

  property p_tick_period;
    @(posedge clk) disable iff (!resetn) tick && $past(tick_cnt) == TICK_LAST |-> gap_cnt == TICK_LAST;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

  property p_eval_after_tick;
    @(posedge clk) disable iff (!resetn) tick |-> s_capture;
  endproperty
  a_eval_after_tick: assert property (p_eval_after_tick) else $error("no evaluation");

  property p_pickup;
    @(posedge clk) disable iff (!resetn)
      eval && state == ST_IDLE && over && load_ok && stage_on && !blk
      && delay_mode != DLY_INSTANT && !force_active |=> state == ST_START && start_out;
  endproperty
  a_pickup: assert property (p_pickup) else $error("missed pick-up");

  property p_instant;
    @(posedge clk) disable iff (!resetn)
      eval && state == ST_IDLE && over && load_ok && stage_on && !blk
      && delay_mode == DLY_INSTANT |=> state == ST_TRIP;
  endproperty
  a_instant: assert property (p_instant) else $error("instant trip late");

  property p_dropout;
    @(posedge clk) disable iff (!resetn) eval && state != ST_IDLE && drop |=> state == ST_IDLE;
  endproperty
  a_dropout: assert property (p_dropout) else $error("no drop-out");

  property p_block_pickup;
    @(posedge clk) disable iff (!resetn)
      eval && over && load_ok && stage_on && blk && !force_active |=> blocked_out && !start_out;
  endproperty
  a_block_pickup: assert property (p_block_pickup) else $error("block ignored");

  property p_min_load;
    @(posedge clk) disable iff (!resetn)
      eval && sel_ratio && !load_ok |=> state == ST_IDLE;
  endproperty
  a_min_load: assert property (p_min_load) else $error("low load picked up");

  property p_force;
    @(posedge clk) disable iff (!resetn) force_active |=> condition == $past(force_status);
  endproperty
  a_force: assert property (p_force) else $error("force ignored");

  property p_behaviour;
    @(posedge clk) disable iff (!resetn) !mode_permit |=> behaviour == MODE_ON;
  endproperty
  a_behaviour: assert property (p_behaviour) else $error("mode leak");

endmodule // ubp_unbalance_stage

// file: verif/ubp_meas_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Measurement front end model
// ----------------------------------------
module ubp_meas_model (
  input  logic             clk,
  input  logic [15:0]      pos_req,
  input  logic [15:0]      neg_req,
  input  logic [15:0]      ph_req,
  output logic [15:0]      pos_seq_mag,
  output logic [15:0]      neg_seq_mag,
  output logic [15:0]      zero_seq_mag,
  output logic [15:0]      ang,
  output logic [2:0][15:0] phase_mag
);
  // Registered like a real front end; angle and zero sequence wander
  always_ff @(posedge clk) begin
    pos_seq_mag  <= pos_req;
    neg_seq_mag  <= neg_req;
    zero_seq_mag <= pos_req ^ 16'hA5A5;
    ang          <= pos_req ^ neg_req ^ 16'h5A5A;
    phase_mag    <= {ph_req, ph_req, ph_req};
  end
endmodule // ubp_meas_model

// file: verif/testbench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  import ubp_pkg::*;
  localparam int TC = 50;  // Short tick keeps the run small
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0, resetn = 1'b0, block_in = 1'b0, mode_permit = 1'b0, force_permit = 1'b0;
  logic sel = SEL_NEG_PU;
  ubp_mode_t mode = MODE_ON;
  ubp_cond_t fstat = COND_NORMAL;
  ubp_delay_t dmode = DLY_INSTANT;
  logic [19:0] fixed = 20'h00000;
  logic [2:0] grp = 3'h0;
  logic [15:0] pos_req = 16'h0000, neg_req = 16'h0000, ph_req = 16'h0000;
  // Group 1 has a higher level to show a live group switch
  logic [7:0][15:0] neg_lvl = {{6{16'h0014}}, 16'h0030, 16'h0014};
  logic [7:0][15:0] rat_lvl = {8{16'h07D0}};
  logic [15:0] pos_m, neg_m, zero_m, ang, ratio, rz, rp, rn, rza;
  logic [2:0][15:0] ph_m;
  logic start_out, trip_out, blocked_out, strobe;
  ubp_cond_t condition;
  ubp_mode_t behaviour;
  int mismatches = 0, samples_checked = 0, cycles = 0, strobes = 0;
  // Inverse multiplier; needs two evaluations of excess at 1.6 x level
  logic [39:0] inv_k = 40'h00_002D_C6C0;
  always #10 clk = ~clk;
  ubp_meas_model i_model (.clk(clk), .pos_req(pos_req), .neg_req(neg_req), .ph_req(ph_req),
    .pos_seq_mag(pos_m), .neg_seq_mag(neg_m), .zero_seq_mag(zero_m), .ang(ang),
    .phase_mag(ph_m));
  ubp_unbalance_stage #(.TICK_CYCLES(TC)) i_dut (.clk(clk), .resetn(resetn),
    .block_in(block_in), .pos_seq_mag(pos_m), .neg_seq_mag(neg_m), .zero_seq_mag(zero_m),
    .pos_seq_ang(ang), .neg_seq_ang(ang), .zero_seq_ang(ang), .phase_mag(ph_m),
    .min_load_level(16'h0032), .group_sel(grp), .neg_seq_pickup_level(neg_lvl),
    .seq_ratio_pickup_level(rat_lvl), .mode_permit(mode_permit),
    .node_operating_mode(mode), .force_permit(force_permit), .force_status(fstat),
    .magnitude_select(sel), .delay_mode(dmode), .fixed_time_delay(fixed),
    .inverse_time_delay(inv_k), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .condition(condition), .behaviour(behaviour),
    .meas_set_ratio(ratio), .record_strobe(strobe), .record_zero_mag(rz),
    .record_pos_ang(rp), .record_neg_ang(rn), .record_zero_ang(rza));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Wait past n full ticks plus eval, then sample off the edge
  task automatic settle(input int n);
    repeat (n * TC + 4) @(posedge clk);
    #1;
  endtask
  // Present new magnitudes and let one evaluation land
  task automatic drv(input logic [15:0] n, input logic [15:0] p, input logic [15:0] h);
    @(posedge clk);
    neg_req <= n;
    pos_req <= p;
    ph_req  <= h;
    settle(1);
  endtask
  // Hang guard, well above the planned run
  always @(posedge clk) begin
    cycles++;
    strobes += int'(strobe === 1'b1); // Record entries seen
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(condition, COND_NORMAL)
    `CHK(behaviour, MODE_ON)
    drv(16'h0015, 16'h0064, 16'h0040);
    `CHK(condition, COND_TRIP)
    `CHK(trip_out, 1'b1)
    settle(1);
    `CHK(ratio, 16'h041A)
    `CHK(strobes, 1)
    `CHK(rz, 16'hA5C1)
    `CHK({rp, rn, rza}, {3{16'h5A2B}})
    drv(16'h0014, 16'h0064, 16'h0040);
    `CHK(condition, COND_TRIP)
    drv(16'h0013, 16'h0064, 16'h0040);
    `CHK(condition, COND_NORMAL)
    $display("pickup and hysteresis done");
    @(posedge clk) grp <= 3'h1;
    drv(16'h0020, 16'h0064, 16'h0040);
    `CHK(condition, COND_NORMAL)
    @(posedge clk) grp <= 3'h0;
    settle(1);
    `CHK(condition, COND_TRIP)
    drv(16'h0000, 16'h0064, 16'h0040);
    $display("group switch done");
    @(posedge clk) block_in <= 1'b1;
    drv(16'h0020, 16'h0064, 16'h0040);
    `CHK(condition, COND_BLOCKED)
    `CHK({blocked_out, start_out}, 2'h2)
    @(posedge clk) block_in <= 1'b0;
    drv(16'h0000, 16'h0064, 16'h0040);
    $display("block at pickup done");
    @(posedge clk) dmode <= DLY_FIXED;
    fixed <= 20'h00003;
    drv(16'h0020, 16'h0064, 16'h0040);
    `CHK({start_out, trip_out}, 2'h2)
    @(posedge clk) block_in <= 1'b1;
    settle(1);
    `CHK(start_out, 1'b0)
    @(posedge clk) block_in <= 1'b0;
    drv(16'h0000, 16'h0064, 16'h0040);
    drv(16'h0020, 16'h0064, 16'h0040);
    `CHK(condition, COND_START)
    settle(5);
    `CHK(condition, COND_TRIP)
    drv(16'h0000, 16'h0064, 16'h0040);
    @(posedge clk) dmode <= DLY_INVERSE;
    drv(16'h0020, 16'h0064, 16'h0040);
    `CHK(condition, COND_START)
    settle(1);
    `CHK(condition, COND_START)
    settle(2);
    `CHK(condition, COND_TRIP)
    drv(16'h0000, 16'h0064, 16'h0040);
    @(posedge clk) dmode <= DLY_INSTANT;
    $display("fixed delay done");
    @(posedge clk) sel <= SEL_RATIO;
    drv(16'h0019, 16'h0064, 16'h0010);
    `CHK(condition, COND_NORMAL)
    drv(16'h0019, 16'h0064, 16'h0040);
    `CHK(condition, COND_TRIP)
    drv(16'h0000, 16'h0064, 16'h0040);
    @(posedge clk) sel <= SEL_NEG_PU;
    $display("ratio mode done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) force_permit <= 1'b1;
      fstat <= ubp_cond_t'(i);
      repeat (3) @(posedge clk);
      #1;
      `CHK(condition, ubp_cond_t'(i))
    end
    @(posedge clk) force_permit <= 1'b0;
    $display("force done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) mode_permit <= 1'b1;
      mode <= ubp_mode_t'(i);
      repeat (3) @(posedge clk);
      #1;
      `CHK(behaviour, ubp_mode_t'(i))
    end
    drv(16'h0020, 16'h0064, 16'h0040);
    `CHK(condition, COND_NORMAL)
    $display("node mode done");
    print_verdict();
  end
endmodule // testbench
